/* File: common/cssrs_pkg.sv */
// constants and types of the core special register space
// assumes one 100 MHz system clock shared with the instruction core
package cssrs_pkg;

  // ----------------------------------------------------------------
  // data-memory map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IND_PORT = 8'h00;  // indirect data port
  localparam logic [7:0] ADDR_POINTER  = 8'h01;  // indirect pointer
  localparam logic [7:0] ADDR_ACC      = 8'h05;  // alu result register
  localparam logic [7:0] ADDR_PC_LOW   = 8'h06;  // program counter low byte
  localparam logic [7:0] ADDR_TBLP     = 8'h07;  // table pointer
  localparam logic [7:0] ADDR_FLAGS    = 8'h0A;  // core flags
  localparam logic [7:0] SFR_END       = 8'h10;  // first general purpose address

  // ----------------------------------------------------------------
  // core flags layout and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_TO        = 5;      // watchdog expired flag
  localparam int         BIT_PDF       = 4;      // powerdown flag
  localparam int         ARITH_W       = 4;      // bits 3..0 are writable
  localparam logic [1:0] FLAGS_UNUSED  = 2'h0;   // bits 7..6 read zero
  localparam logic [3:0] ARITH_RESET   = 4'h0;   // arithmetic flags at reset
  localparam logic [7:0] DATA_RESET    = 8'h00;  // data registers at reset
  localparam logic [7:0] READ_ZERO     = 8'h00;  // unused address reads

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         TBL_CYCLES    = 2;      // table read occupancy
  localparam int         PC_WIDTH      = 9;      // 512 word program space

  // ----------------------------------------------------------------
  // alu operations, result lands in the alu result register unless a direct store to it comes in the same cycle
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_PASS, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
    OP_CPL, OP_INC, OP_DEC, OP_RL, OP_RR, OP_RLC, OP_RRC, OP_CLR
  } cssrs_aluop_type;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE, ST_RAM_RD, ST_TBL_FETCH, ST_TBL_STORE
  } cssrs_state_type;

endpackage : cssrs_pkg

/* File: verilog/cssrs_alu.sv */
// combinational alu with flag generation for the special register space
// assumes operand a is the alu result register and b the memory operand
`timescale 1ns/1ps
module cssrs_alu (
  // operation
  input  wire cssrs_pkg::cssrs_aluop_type aluOp,
  input  wire logic [7:0]                 opA,
  input  wire logic [7:0]                 opB,
  input  wire logic                       carryIn,
  // result and flags
  output logic       [7:0]                result,
  output logic       [3:0]                flagsOut,
  output logic       [3:0]                flagsUpd
);

  // ----------------------------------------------------------------
  // shared adder: subtract is a plus inverted b plus carry
  // ----------------------------------------------------------------
  always_comb begin
    logic       isSub;
    logic       cin;
    logic [7:0] bOp;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] sum7;
    cin      = carryIn;
    isSub    = (aluOp == cssrs_pkg::OP_SUB) || (aluOp == cssrs_pkg::OP_SBC);
    bOp      = isSub ? ~opB : opB;
    // plain ops force carry in, chained ops use the carry flag
    case (aluOp)
      cssrs_pkg::OP_ADD: cin = 1'h0;
      cssrs_pkg::OP_SUB: cin = 1'h1;
      default:           cin = carryIn;
    endcase
    sum9     = {1'h0, opA} + {1'h0, bOp} + {8'h00, cin};
    sum5     = {1'h0, opA[3:0]} + {1'h0, bOp[3:0]} + {4'h0, cin};
    sum7     = {1'h0, opA[6:0]} + {1'h0, bOp[6:0]} + {7'h00, cin};
    result   = opB;
    flagsUpd = 4'h0;
    // flag order: sign wrap, zero, half carry, carry
    flagsOut = {sum7[7] ^ sum9[8], 1'h0, sum5[4], sum9[8]};  // RL14 RL16 RL17
    case (aluOp)
      cssrs_pkg::OP_ADD, cssrs_pkg::OP_ADC,
      cssrs_pkg::OP_SUB, cssrs_pkg::OP_SBC: begin
        result   = sum9[7:0];
        flagsUpd = 4'hF;
      end
      cssrs_pkg::OP_AND: begin
        result   = opA & opB;
        flagsUpd = 4'h4;
      end
      cssrs_pkg::OP_OR: begin
        result   = opA | opB;
        flagsUpd = 4'h4;
      end
      cssrs_pkg::OP_XOR: begin
        result   = opA ^ opB;
        flagsUpd = 4'h4;
      end
      cssrs_pkg::OP_CPL: begin
        result   = ~opB;
        flagsUpd = 4'h4;
      end
      cssrs_pkg::OP_INC: begin
        result   = opB + 8'h01;
        flagsUpd = 4'h4;
      end
      cssrs_pkg::OP_DEC: begin
        result   = opB - 8'h01;
        flagsUpd = 4'h4;
      end
      cssrs_pkg::OP_RL:  result = {opB[6:0], opB[7]};
      cssrs_pkg::OP_RR:  result = {opB[0], opB[7:1]};
      // carry takes the bit shifted out, old carry shifts in
      cssrs_pkg::OP_RLC: begin
        result      = {opB[6:0], carryIn};  // RL18
        flagsOut[0] = opB[7];
        flagsUpd    = 4'h1;
      end
      cssrs_pkg::OP_RRC: begin
        result      = {carryIn, opB[7:1]};  // RL18
        flagsOut[0] = opB[0];
        flagsUpd    = 4'h1;
      end
      cssrs_pkg::OP_CLR: result = 8'h00;
      default:           result = opB;
    endcase
    flagsOut[2] = (result == 8'h00);  // RL15
  end

endmodule : cssrs_alu

/* File: verilog/cssrs_top.sv */
// core special register space: indirect port, pointer, alu result,
// program counter low byte, table pointer and core flags
// assumes the core issues one request at a time and waits on rdValid,
// tableBusy and dummyCycle; program memory and ram answer combinationally
//
// Summary of operation
// RL1 - unused special addresses read as zero
// RL2 - indirect port accesses go to pointer address
// RL3 - indirect port itself reads zero, stores nothing; here a pointer of zero reads and writes ram address zero
// RL4 - pointer is a normal read/write 8-bit register
// RL5 - indirect pair reaches bank zero only
// RL6 - alu results land in result register
// RL7 - program counter low write jumps within page
// RL8 - jump via low byte inserts one dummy cycle
// RL9 - table pointer addresses table read, low byte stored
// RL10 - table read occupies two instruction cycles
// RL11 - flag writes never touch watchdog, powerdown flags
// RL12 - watchdog flag: set timeout, cleared refresh/standby
// RL13 - powerdown flag: set standby, cleared by refresh
// RL14 - bit 3 flags sign wrap
// RL15 - bit 2 flags zero result
// RL16 - bit 1 flags low nibble carry
// RL17 - bit 0 flags carry or no borrow
// RL18 - rotate through carry updates and uses carry
// RL19 - flag bits 7 and 6 read zero
// RL20 - watchdog and powerdown flags zero after power-up
// RL21 - flags are never saved automatically
// RL22 - writes to unused special addresses ignored
`timescale 1ns/1ps
module cssrs_top #(
  parameter int PC_W = cssrs_pkg::PC_WIDTH  // program counter width
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  // core data-memory access
  input  wire logic [7:0]                 memAddr,
  input  wire logic                       memRead,
  input  wire logic                       memWrite,
  input  wire logic [7:0]                 memWrData,
  output logic      [7:0]                 memRdData,
  output logic                            rdValid,
  // alu request from the core
  input  wire logic                       aluStrobe,
  input  wire cssrs_pkg::cssrs_aluop_type aluOp,
  input  wire logic [7:0]                 aluOperand,
  // system events
  input  wire logic                       wdtTimeout,
  input  wire logic                       watchdog_refresh_op,
  input  wire logic                       standbyOp,
  // program counter
  input  wire logic [PC_W-1:0]            pcCurrent,
  output logic                            pcJump,
  output logic      [PC_W-1:0]            pcJumpAddr,
  output logic                            dummyCycle,
  // table read
  input  wire logic                       tableReadReq,
  input  wire logic                       tableLastPage,
  input  wire logic [7:0]                 tableDest,
  output logic                            progRead,
  output logic      [PC_W-1:0]            progAddr,
  input  wire logic [7:0]                 progRdData,
  output logic                            tableBusy,
  // general purpose ram, bank zero
  output logic                            ramRead,
  output logic                            ramWrite,
  output logic      [7:0]                 ramAddr,
  output logic      [7:0]                 ramWrData,
  input  wire logic [7:0]                 ramRdData,
  // register views for the core
  output logic      [7:0]                 accOut,
  output logic      [7:0]                 flagsOut
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                       rstSync1;      // first reset stage
  logic                       rstSync2_n;    // released reset for the design
  cssrs_pkg::cssrs_state_type state_reg;     // sequencer state
  cssrs_pkg::cssrs_state_type state_next;
  logic [7:0]                 pointer_reg;   // indirect pointer
  logic [7:0]                 acc_reg;       // alu result register
  logic [7:0]                 tblp_reg;      // table pointer
  logic [3:0]                 arith_reg;     // sign wrap, zero, half, carry
  logic                       toFlag_reg;    // watchdog expired flag
  logic                       pdFlag_reg;    // powerdown flag
  logic [7:0]                 tblDest_reg;   // table read destination
  logic [7:0]                 tblData_reg;   // fetched low program byte
  logic                       wrEn;          // effective write this cycle
  logic [7:0]                 wrAddr;
  logic [7:0]                 wrData;
  logic                       wrInt;         // write hits the special address range, indirect port excluded
  logic                       wrRam;         // write goes out to ram
  logic [7:0]                 wrRamAddr;
  logic                       rdTake;        // read accepted this cycle
  logic                       rdToRam;       // read goes out to ram
  logic [7:0]                 rdRamAddr;
  logic [7:0]                 rdMux;         // local read data
  logic [7:0]                 aluResult;
  logic [3:0]                 aluFlags;
  logic [3:0]                 aluUpd;

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  // immediate assert; release waits two edges so all flops leave together
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1   <= 1'h0;
      rstSync2_n <= 1'h0;
    end else begin
      rstSync1   <= 1'h1;
      rstSync2_n <= rstSync1;
    end
  end

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  cssrs_alu u_alu (
    .aluOp    (aluOp),
    .opA      (acc_reg),
    .opB      (aluOperand),
    .carryIn  (arith_reg[0]),
    .result   (aluResult),
    .flagsOut (aluFlags),
    .flagsUpd (aluUpd)
  );

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // one write path serves core stores and the table store; the core
  // holds off its own requests while tableBusy is high
  always_comb begin
    if (state_reg == cssrs_pkg::ST_TBL_STORE) begin
      wrEn   = 1'h1;
      wrAddr = tblDest_reg;
      wrData = tblData_reg;  // RL9
    end else begin
      wrEn   = memWrite && (state_reg == cssrs_pkg::ST_IDLE);
      wrAddr = memAddr;
      wrData = memWrData;
    end
    // the port itself never stores, the pointer address takes it
    wrInt     = wrEn && (wrAddr < cssrs_pkg::SFR_END)
                && (wrAddr != cssrs_pkg::ADDR_IND_PORT);  // RL3
    wrRam     = wrEn && !wrInt;
    // 8-bit pointer spans bank zero only, no bank bits exist
    wrRamAddr = (wrAddr == cssrs_pkg::ADDR_IND_PORT) ? pointer_reg : wrAddr;  // RL2 RL5
    rdTake    = memRead && (state_reg == cssrs_pkg::ST_IDLE) && !tableReadReq;
    rdToRam   = (memAddr >= cssrs_pkg::SFR_END)
                || (memAddr == cssrs_pkg::ADDR_IND_PORT);
    rdRamAddr = (memAddr == cssrs_pkg::ADDR_IND_PORT) ? pointer_reg : memAddr;  // RL2 RL5
  end

  // local read mux, anything not held here reads zero
  always_comb begin
    case (memAddr)
      cssrs_pkg::ADDR_POINTER: rdMux = pointer_reg;  // RL4
      cssrs_pkg::ADDR_ACC:     rdMux = acc_reg;
      cssrs_pkg::ADDR_PC_LOW:  rdMux = pcCurrent[7:0];
      cssrs_pkg::ADDR_TBLP:    rdMux = tblp_reg;
      cssrs_pkg::ADDR_FLAGS:   rdMux = {cssrs_pkg::FLAGS_UNUSED, toFlag_reg,
                                        pdFlag_reg, arith_reg};  // RL19
      default:                 rdMux = cssrs_pkg::READ_ZERO;  // RL1
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // table read wins over a plain read offered in the same cycle
  always_comb begin
    case (state_reg)
      cssrs_pkg::ST_IDLE: begin
        if (tableReadReq) begin
          state_next = cssrs_pkg::ST_TBL_FETCH;
        end else if (rdTake && rdToRam) begin
          state_next = cssrs_pkg::ST_RAM_RD;
        end else begin
          state_next = cssrs_pkg::ST_IDLE;
        end
      end
      cssrs_pkg::ST_RAM_RD:    state_next = cssrs_pkg::ST_IDLE;
      cssrs_pkg::ST_TBL_FETCH: state_next = cssrs_pkg::ST_TBL_STORE;  // RL10
      cssrs_pkg::ST_TBL_STORE: state_next = cssrs_pkg::ST_IDLE;
      default:                 state_next = cssrs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      state_reg <= cssrs_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // table read
  // ----------------------------------------------------------------
  // busy covers fetch and store, the two cycles of the instruction
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      progRead    <= 1'h0;
      progAddr    <= '0;
      tableBusy   <= 1'h0;
      tblDest_reg <= cssrs_pkg::DATA_RESET;
      tblData_reg <= cssrs_pkg::DATA_RESET;
    end else begin
      progRead  <= (state_next == cssrs_pkg::ST_TBL_FETCH);
      tableBusy <= (state_next == cssrs_pkg::ST_TBL_FETCH)
                   || (state_next == cssrs_pkg::ST_TBL_STORE);  // RL10
      if (state_reg == cssrs_pkg::ST_IDLE && tableReadReq) begin
        tblDest_reg <= tableDest;
        // page is the last one or the current one, pointer gives the rest
        progAddr    <= {tableLastPage ? {(PC_W-8){1'h1}} : pcCurrent[PC_W-1:8],
                        tblp_reg};  // RL9
      end
      // only the low program byte is kept
      if (state_reg == cssrs_pkg::ST_TBL_FETCH) begin
        tblData_reg <= progRdData;  // RL9
      end
    end
  end

  // ----------------------------------------------------------------
  // pointer and table pointer
  // ----------------------------------------------------------------
  // increments and decrements arrive as ordinary read-modify-writes
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      pointer_reg <= cssrs_pkg::DATA_RESET;
      tblp_reg    <= cssrs_pkg::DATA_RESET;
    end else begin
      if (wrInt && wrAddr == cssrs_pkg::ADDR_POINTER) begin
        pointer_reg <= wrData;  // RL4
      end
      if (wrInt && wrAddr == cssrs_pkg::ADDR_TBLP) begin
        tblp_reg <= wrData;  // RL9
      end
    end
  end

  // ----------------------------------------------------------------
  // alu result register
  // ----------------------------------------------------------------
  // a direct store wins over an alu result offered in the same cycle
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      acc_reg <= cssrs_pkg::DATA_RESET;
    end else if (wrInt && wrAddr == cssrs_pkg::ADDR_ACC) begin
      acc_reg <= wrData;
    end else if (aluStrobe) begin
      acc_reg <= aluResult;  // RL6
    end
  end

  // ----------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------
  // reset to zero for a defined start although software must not rely
  // on it; nothing here saves them on a call or an interrupt
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      arith_reg <= cssrs_pkg::ARITH_RESET;
    end else if (wrInt && wrAddr == cssrs_pkg::ADDR_FLAGS) begin
      arith_reg <= wrData[cssrs_pkg::ARITH_W-1:0];  // RL11
    end else if (aluStrobe) begin
      arith_reg <= (aluFlags & aluUpd) | (arith_reg & ~aluUpd);  // RL14 RL15 RL16 RL17 RL18 RL21
    end
  end

  // ----------------------------------------------------------------
  // watchdog expired and powerdown flags
  // ----------------------------------------------------------------
  // software writes never reach these; a set wins over a clear
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      toFlag_reg <= 1'h0;  // RL20
      pdFlag_reg <= 1'h0;  // RL20
    end else begin
      if (wdtTimeout) begin
        toFlag_reg <= 1'h1;  // RL12
      end else if (watchdog_refresh_op || standbyOp) begin
        toFlag_reg <= 1'h0;  // RL12
      end
      if (standbyOp) begin
        pdFlag_reg <= 1'h1;  // RL13
      end else if (watchdog_refresh_op) begin
        pdFlag_reg <= 1'h0;  // RL13
      end
    end
  end

  // ----------------------------------------------------------------
  // program counter low byte jump
  // ----------------------------------------------------------------
  // low byte only: target stays on the page; dummy cycle follows by one edge
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      pcJump     <= 1'h0;
      pcJumpAddr <= '0;
      dummyCycle <= 1'h0;
    end else begin
      pcJump     <= wrInt && (wrAddr == cssrs_pkg::ADDR_PC_LOW);  // RL7
      dummyCycle <= pcJump;  // RL8
      if (wrInt && wrAddr == cssrs_pkg::ADDR_PC_LOW) begin
        pcJumpAddr <= {pcCurrent[PC_W-1:8], wrData};  // RL7
      end
    end
  end

  // ----------------------------------------------------------------
  // ram side
  // ----------------------------------------------------------------
  // unused special addresses set wrInt but no register decodes them
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      ramRead   <= 1'h0;
      ramWrite  <= 1'h0;
      ramAddr   <= cssrs_pkg::DATA_RESET;
      ramWrData <= cssrs_pkg::DATA_RESET;
    end else begin
      ramRead  <= rdTake && rdToRam;  // RL2
      ramWrite <= wrRam;  // RL2 RL22
      if (wrRam) begin
        ramAddr   <= wrRamAddr;
        ramWrData <= wrData;
      end else if (rdTake && rdToRam) begin
        ramAddr <= rdRamAddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // local reads answer one edge after the request, ram reads two
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      memRdData <= cssrs_pkg::READ_ZERO;
      rdValid   <= 1'h0;
    end else if (state_reg == cssrs_pkg::ST_RAM_RD) begin
      memRdData <= ramRdData;
      rdValid   <= 1'h1;
    end else if (rdTake && !rdToRam) begin
      memRdData <= rdMux;  // RL1
      rdValid   <= 1'h1;
    end else begin
      rdValid   <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSync2_n) begin
    if (!rstSync2_n) begin
      accOut   <= cssrs_pkg::DATA_RESET;
      flagsOut <= cssrs_pkg::DATA_RESET;
    end else begin
      accOut   <= acc_reg;
      flagsOut <= {cssrs_pkg::FLAGS_UNUSED, toFlag_reg, pdFlag_reg, arith_reg};  // RL19
    end
  end

endmodule : cssrs_top

/* File: verif/cssrs_mem_model.sv */
// far-side model: bank zero ram and program memory low bytes
// assumes registered ram and program strobes from the register space
`timescale 1ns/1ps
module cssrs_mem_model (
  // clock
  input  wire logic       sys_clk,
  // ram side
  input  wire logic       ramRead,
  input  wire logic       ramWrite,
  input  wire logic [7:0] ramAddr,
  input  wire logic [7:0] ramWrData,
  output logic      [7:0] ramRdData,
  // program side
  input  wire logic       progRead,
  input  wire logic [8:0] progAddr,
  output logic      [7:0] progRdData
);
  logic [7:0] ram [256];  // one bank, eight address bits
  // writes land at the edge closing the ramWrite cycle
  always @(posedge sys_clk) if (ramWrite) ram[ramAddr] <= ramWrData;
  // idle data inverted so a stale sample never matches
  assign ramRdData  = ramRead ? ram[ramAddr] : ~ram[ramAddr];
  assign progRdData = {8{!progRead}} ^ progAddr[7:0] ^ 8'h5A ^ {7'h0, progAddr[8]};
endmodule : cssrs_mem_model

/* File: verif/cssrs_checker.sv */
// checker: port-level timing of flags, jumps, table and ram reads
// assumes it is bound into cssrs_top and sees its ports only
`timescale 1ns/1ps
module cssrs_checker #(
  parameter int PC_W = 9  // program counter width
) (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            reset_n,
  // core access and answers
  input wire logic [7:0]      memAddr,
  input wire logic            memWrite,
  input wire logic            rdValid,
  input wire logic            ramRead,
  // events
  input wire logic            wdtTimeout,
  input wire logic            watchdog_refresh_op,
  input wire logic            standbyOp,
  // jump, table, flags
  input wire logic [PC_W-1:0] pcCurrent,
  input wire logic            pcJump,
  input wire logic [PC_W-1:0] pcJumpAddr,
  input wire logic            dummyCycle,
  input wire logic            tableBusy,
  input wire logic [7:0]      flagsOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // flagsOut lags the flag register by one cycle, hence the ##2
  wdt_set_a: assert property (wdtTimeout |-> ##2 flagsOut[5])
    else $error("timeout flag not set");
  standby_set_a: assert property (standbyOp |-> ##2 flagsOut[4] && !flagsOut[5])
    else $error("standby flags wrong");
  refresh_clear_a: assert property (watchdog_refresh_op && !wdtTimeout && !standbyOp
    |-> ##2 flagsOut[5:4] == 2'h0)
    else $error("refresh left flags set");
  flag_protect_a: assert property (memWrite && memAddr == 8'h0A && !wdtTimeout && !standbyOp
    && !watchdog_refresh_op |-> ##2 flagsOut[5:4] == $past(flagsOut[5:4]))
    else $error("write touched hardware flags");
  unused_bits_a: assert property (flagsOut[7:6] == 2'h0)
    else $error("flag bits 7..6 not zero");
  dummy_follow_a: assert property (pcJump |=> dummyCycle)
    else $error("no dummy cycle after jump");
  jump_page_a: assert property (pcJump |-> (pcJumpAddr >> 8) == ($past(pcCurrent) >> 8))
    else $error("jump left the page");
  table_busy_a: assert property ($rose(tableBusy) |-> tableBusy ##1 tableBusy ##1 !tableBusy)
    else $error("table read not two cycles");
  ram_answer_a: assert property (ramRead |=> rdValid)
    else $error("indirect read unanswered");
endmodule : cssrs_checker
bind cssrs_top cssrs_checker #(.PC_W(PC_W)) u_chk (.*);

/* File: verif/tb_top.sv */
// bench: register reads and writes, alu, events, jump and table read
// assumes cssrs_top with default PC_W and the memory model beside it
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk = 0, reset_n = 0, memRead = 0, memWrite = 0, aluStrobe = 0;
  logic       tableReadReq = 0, tableLastPage = 1;     // table request, last page
  logic       wdtTimeout = 0, standbyOp = 0, watchdog_refresh_op = 0;
  logic [7:0] accOut, flagsOut;
  logic [7:0] memAddr = 0, memWrData = 0, aluOperand = 0, tableDest = 8'h15;
  logic [8:0] pcCurrent = 9'h1C3;                      // page 1 while jumping
  logic [7:0] memRdData, ramAddr, ramWrData, ramRdData, progRdData;
  logic       rdValid, pcJump, dummyCycle, progRead, tableBusy, ramRead, ramWrite;
  logic [8:0] pcJumpAddr, progAddr;
  int         failures = 0, tests_run = 0, cycles = 0;
  logic [7:0] unused [10] = '{8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0D,
                              8'h0E, 8'h0F};
  cssrs_pkg::cssrs_aluop_type aluOp = cssrs_pkg::OP_PASS;
  cssrs_top dut (.*);
  cssrs_mem_model mem (.*);
  always #5 sys_clk = ~sys_clk;
  // compare one value and count it; a mismatch is shown at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // write: held across exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 {memWrite, memAddr, memWrData} = {1'b1, a, d};
    @(posedge sys_clk) #1 memWrite = 0;
  endtask : wr
  // read: answer awaited a bounded time, ram reads need one more cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) #1 {memRead, memAddr} = {1'b1, a};
    @(posedge sys_clk) #1 memRead = 0;
    for (int k = 0; k < 4 && !rdValid; k++) @(posedge sys_clk) #1;
    chk({7'h0, rdValid, memRdData}, {8'h01, e});
  endtask : rd
  // alu request, one strobe
  task automatic alu(input cssrs_pkg::cssrs_aluop_type op, input logic [7:0] b);
    @(posedge sys_clk) #1 aluStrobe = 1;
    aluOp = op;
    aluOperand = b;
    @(posedge sys_clk) #1 aluStrobe = 0;
  endtask : alu
  // one-cycle system event pulse
  task automatic ev(input logic [2:0] e);
    @(posedge sys_clk) #1 {wdtTimeout, standbyOp, watchdog_refresh_op} = e;
    @(posedge sys_clk) #1 {wdtTimeout, standbyOp, watchdog_refresh_op} = 3'h0;
  endtask : ev
  task automatic end_of_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // hang guard, the sequence needs about 110 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1;
    repeat (3) @(posedge sys_clk);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h00);
    wr(cssrs_pkg::ADDR_POINTER, 8'h12);
    rd(cssrs_pkg::ADDR_POINTER, 8'h12);
    wr(cssrs_pkg::ADDR_IND_PORT, 8'hA5);
    rd(cssrs_pkg::ADDR_IND_PORT, 8'hA5);
    rd(8'h12, 8'hA5);
    wr(cssrs_pkg::ADDR_ACC, 8'h7F);
    foreach (unused[i]) begin
      wr(unused[i], 8'hFF);
      rd(unused[i], 8'h00);
    end
    rd(cssrs_pkg::ADDR_ACC, 8'h7F);
    wr(cssrs_pkg::ADDR_FLAGS, 8'hFF);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h0F);
    wr(cssrs_pkg::ADDR_FLAGS, 8'h00);
    alu(cssrs_pkg::OP_ADD, 8'h01);
    rd(cssrs_pkg::ADDR_ACC, 8'h80);
    chk(accOut, 8'h80);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h0A);
    alu(cssrs_pkg::OP_SUB, 8'h80);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h07);
    alu(cssrs_pkg::OP_RLC, 8'h00);
    rd(cssrs_pkg::ADDR_ACC, 8'h01);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h06);
    ev(3'b100);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h26);
    ev(3'b010);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h16);
    ev(3'b001);
    rd(cssrs_pkg::ADDR_FLAGS, 8'h06);
    chk(flagsOut, 8'h06);
    wr(cssrs_pkg::ADDR_PC_LOW, 8'h44);
    chk({pcJump, pcJumpAddr}, {1'b1, 9'h144});
    @(posedge sys_clk) #1 chk(dummyCycle, 1'b1);
    wr(cssrs_pkg::ADDR_TBLP, 8'h06);
    @(posedge sys_clk) #1 tableReadReq = 1;
    @(posedge sys_clk) #1 tableReadReq = 0;
    chk({progRead, tableBusy, progAddr}, {2'b11, 9'h106});
    @(posedge sys_clk) #1 chk(tableBusy, 1'b1);
    @(posedge sys_clk) #1 chk(tableBusy, 1'b0);
    rd(8'h15, 8'h06 ^ 8'h5A ^ 8'h01);
    end_of_test();
  end
endmodule : tb_top
